// ---- rfd_defines.svh ----
/*
  Constants of the fibre / differential direction controller.
  Assumes a single 200 MHz clock and data lines that rest at the mark level.
*/
`ifndef RFD_DEFINES_SVH
`define RFD_DEFINES_SVH

// Clock rate in MHz
`define RFD_CLK_MHZ        200
// Switchover delay from send to receive, in ns
`define RFD_SWITCH_NS      10000
// Switchover delay in clock cycles, rounded up
`define RFD_HOLD_CYCLES    ((`RFD_SWITCH_NS * `RFD_CLK_MHZ + 999) / 1000)
// Width of the switchover counter
`define RFD_HOLD_W         11
// Width of the idle run counter seen by the checks
`define RFD_RUN_W          12
// Resting level of both serial data lines
`define RFD_IDLE_LEVEL     1'b1
// FIFO geometry in the fibre-to-bus path
`define RFD_FIFO_DEPTH     4
`define RFD_FIFO_WIDTH     1
// Cycles from fibre input to bus data output once the FIFO is primed
`define RFD_PATH_LAT       6
// Cycles after reset before the fibre path latency is fixed
`define RFD_PRIME_CYCLES   4'h8
`define RFD_PRIME_W        4

`endif

// ---- rfd_pkg.sv ----
/*
  Types of the fibre / differential direction controller.
  Assumes rfd_defines.svh is on the include path.
*/
package rfd_pkg;

  // Operating modes, Gray coded along full duplex -> echo -> no echo
  typedef enum logic [1:0] {
    MODE_FULL_DUPLEX = 2'h0,
    MODE_ECHO        = 2'h1,
    MODE_NO_ECHO     = 2'h3
  } rfd_mode_type;

  // Driver direction states, Gray coded along listen -> drive -> hold
  typedef enum logic [1:0] {
    DIR_LISTEN = 2'h0,
    DIR_DRIVE  = 2'h1,
    DIR_HOLD   = 2'h3
  } rfd_dir_type;

  // Configuration switch bank
  typedef struct packed {
    logic mode_select_a;
    logic mode_select_b;
    logic mode_select_d;
  } rfd_switch_type;

  // One sampled level of the fibre receive line
  typedef struct packed {
    logic level;
  } rfd_sample_type;

endpackage : rfd_pkg

// ---- rfd_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a power-of-two depth and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module rfd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign out_valid = (level != '0);
  // A pop in the same cycle frees a slot, so a full FIFO still accepts
  assign in_ready  = (level != FULL_LEVEL) || (out_ready && out_valid);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level <= '0;
    end else if (push && !pop) begin
      level <= level + 1'b1;
    end else if (pop && !push) begin
      level <= level - 1'b1;
    end
  end

endmodule : rfd_fifo

// ---- rfd_direction_ctrl.sv ----
/*
  Fibre / differential bus converter core with automatic driver direction.
  Assumes static mode switches, inputs synchronous to clk, and data lines
  that rest at the mark level between characters.
*/
// What this block does
// RL1 - Pass one data line each way unchanged
// RL2 - Decode mode from static configuration switches
// RL3 - Full duplex keeps driver and receiver on
// RL4 - Auto modes enable driver when data starts
// RL5 - Auto modes release driver after transmission ends
// RL6 - Echo mode keeps receiver always enabled
// RL7 - No-echo mode mutes receiver while driving
// RL8 - Wait ten microseconds before releasing driver
// RL9 - Any format, zero to 115200 baud
// RL10 - Idle for whole delay ends transmission
`timescale 1ns/1ps
`include "rfd_defines.svh"

module rfd_direction_ctrl
  import rfd_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Configuration switches
  input  wire rfd_switch_type mode_switch,
  // Fibre side
  input  wire logic           fiber_rx,
  output logic                fiber_tx,
  // Differential side
  input  wire logic           diff_rx,
  output logic                diff_rx_en,
  output logic                diff_tx_data,
  output logic                diff_tx_en,
  // Status
  output rfd_mode_type        mode,
  output logic                mode_fault,
  output rfd_dir_type         dir_state
);

  localparam logic [`RFD_HOLD_W-1:0] HOLD_LAST  = `RFD_HOLD_W'(`RFD_HOLD_CYCLES - 1);
  localparam logic [`RFD_HOLD_W-1:0] HOLD_FIRST = `RFD_HOLD_W'(1);
  localparam logic [`RFD_RUN_W-1:0]  RUN_MAX    = {`RFD_RUN_W{1'b1}};
  localparam logic [`RFD_RUN_W-1:0]  RUN_HOLD   = `RFD_RUN_W'(`RFD_HOLD_CYCLES);
  localparam logic [2:0]             FIFO_LEVEL_FULL = 3'(`RFD_FIFO_DEPTH);

  rfd_mode_type           next_mode;
  logic                   next_fault;
  rfd_dir_type            next_dir;
  logic [`RFD_HOLD_W-1:0] hold_cnt;
  logic [`RFD_HOLD_W-1:0] next_hold_cnt;
  logic                   next_rx_en;
  logic                   next_tx_en;
  logic                   fiber_busy;
  rfd_sample_type         fib_sample;
  rfd_sample_type         fifo_out;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [2:0]             fifo_level;

  // Mode decode; illegal switch settings fall back to full duplex
  always_comb begin
    next_fault = 1'b0;
    if (!mode_switch.mode_select_d) begin // RL2
      next_mode  = MODE_FULL_DUPLEX;
      next_fault = 1'b1;
    end else if (!mode_switch.mode_select_a && !mode_switch.mode_select_b) begin // RL2
      next_mode = MODE_FULL_DUPLEX;
    end else if (!mode_switch.mode_select_a && mode_switch.mode_select_b) begin // RL2
      next_mode = MODE_ECHO;
    end else if (mode_switch.mode_select_a && mode_switch.mode_select_b) begin // RL2
      next_mode = MODE_NO_ECHO;
    end else begin
      next_mode  = MODE_FULL_DUPLEX;
      next_fault = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode       <= MODE_FULL_DUPLEX;
      mode_fault <= 1'b0;
    end else begin
      mode       <= next_mode;
      mode_fault <= next_fault;
    end
  end

  // Any level other than rest counts as outgoing activity
  assign fiber_busy = (fiber_rx != `RFD_IDLE_LEVEL); // RL4

  // Direction state machine
  always_comb begin
    next_dir      = dir_state;
    next_hold_cnt = hold_cnt;
    case (dir_state)
      DIR_LISTEN: begin
        if (mode != MODE_FULL_DUPLEX && fiber_busy) begin
          next_dir = DIR_DRIVE; // RL4
        end
      end
      DIR_DRIVE: begin
        if (!fiber_busy) begin
          next_dir      = DIR_HOLD;
          next_hold_cnt = HOLD_FIRST;
        end
      end
      DIR_HOLD: begin
        if (fiber_busy) begin
          next_dir = DIR_DRIVE; // RL10
        end else if (hold_cnt == HOLD_LAST) begin
          next_dir = DIR_LISTEN; // RL8
        end else begin
          next_hold_cnt = hold_cnt + 1'b1; // RL8
        end
      end
      default: begin
        next_dir = DIR_LISTEN;
      end
    endcase
    // A switch to full duplex abandons any automatic sequence
    if (mode == MODE_FULL_DUPLEX) begin
      next_dir = DIR_LISTEN;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_state <= DIR_LISTEN;
      hold_cnt  <= '0;
    end else begin
      dir_state <= next_dir;
      hold_cnt  <= next_hold_cnt;
    end
  end

  // Driver and receiver enables
  always_comb begin
    next_tx_en = 1'b1;
    next_rx_en = 1'b1;
    case (mode)
      MODE_FULL_DUPLEX: begin
        next_tx_en = 1'b1; // RL3
        next_rx_en = 1'b1; // RL3
      end
      MODE_ECHO: begin
        next_tx_en = (next_dir != DIR_LISTEN); // RL5
        next_rx_en = 1'b1; // RL6
      end
      MODE_NO_ECHO: begin
        next_tx_en = (next_dir != DIR_LISTEN); // RL5
        next_rx_en = (next_dir == DIR_LISTEN); // RL7
      end
      default: begin
        next_tx_en = 1'b1;
        next_rx_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      diff_tx_en <= 1'b0;
      diff_rx_en <= 1'b0;
    end else begin
      diff_tx_en <= next_tx_en;
      diff_rx_en <= next_rx_en;
    end
  end

  // Bus to fibre; a muted receiver leaves the fibre at rest
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fiber_tx <= `RFD_IDLE_LEVEL;
    end else if (next_rx_en) begin
      fiber_tx <= diff_rx; // RL1
    end else begin
      fiber_tx <= `RFD_IDLE_LEVEL; // RL7
    end
  end

  // Fibre sampler; plain level copy, so no framing or rate setting exists
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fib_sample.level <= `RFD_IDLE_LEVEL;
    end else if (fifo_in_ready) begin
      fib_sample.level <= fiber_rx; // RL9
    end
  end

  // Draining only when full fixes the delay, so the driver is on before data
  assign fifo_out_ready = (fifo_level == FIFO_LEVEL_FULL);

  rfd_fifo #(
    .WIDTH (`RFD_FIFO_WIDTH),
    .DEPTH (`RFD_FIFO_DEPTH)
  ) u_fiber_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (1'b1),
    .in_ready  (fifo_in_ready),
    .in_data   (fib_sample),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      diff_tx_data <= `RFD_IDLE_LEVEL;
    end else if (fifo_out_valid && fifo_out_ready) begin
      diff_tx_data <= fifo_out.level; // RL1
    end
  end

  // Helper counters read only by the checks below
  logic [`RFD_RUN_W-1:0]   idle_run;
  logic [`RFD_PRIME_W-1:0] prime_cnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_run <= '0;
    end else if (fiber_busy) begin
      idle_run <= '0;
    end else if (idle_run != RUN_MAX) begin
      idle_run <= idle_run + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prime_cnt <= '0;
    end else if (prime_cnt != `RFD_PRIME_CYCLES) begin
      prime_cnt <= prime_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  mode_decode_a: assert property (
    mode_switch.mode_select_d && mode_switch.mode_select_a && mode_switch.mode_select_b
    |=> mode == MODE_NO_ECHO)
    else $error("no-echo switch setting not decoded"); // RL2

  fdx_enables_a: assert property (
    mode == MODE_FULL_DUPLEX |=> diff_tx_en && diff_rx_en)
    else $error("full duplex lost an enable"); // RL3

  auto_start_a: assert property (
    mode != MODE_FULL_DUPLEX && dir_state == DIR_LISTEN && fiber_busy
    |=> diff_tx_en)
    else $error("driver not enabled on data start"); // RL4

  release_time_a: assert property (
    $fell(diff_tx_en) && mode != MODE_FULL_DUPLEX && $stable(mode) && $past(dir_state) == DIR_HOLD
    |-> idle_run == RUN_HOLD)
    else $error("driver released at wrong idle time"); // RL8

  busy_keeps_a: assert property (
    diff_tx_en && fiber_busy && mode != MODE_FULL_DUPLEX && $stable(mode)
    |=> diff_tx_en)
    else $error("driver released during activity"); // RL10

  release_due_a: assert property (
    mode != MODE_FULL_DUPLEX && $stable(mode) && idle_run == RUN_HOLD
    |-> !diff_tx_en)
    else $error("driver held past switchover delay"); // RL5

  echo_rx_a: assert property (
    mode == MODE_ECHO |=> diff_rx_en)
    else $error("echo mode muted receiver"); // RL6

  noecho_mute_a: assert property (
    mode == MODE_NO_ECHO && $stable(mode) |-> diff_rx_en == !diff_tx_en)
    else $error("no-echo receiver not opposite driver"); // RL7

  rx_path_a: assert property (
    diff_rx_en |-> fiber_tx == $past(diff_rx))
    else $error("bus data not copied to fibre"); // RL1

  tx_path_a: assert property (
    prime_cnt == `RFD_PRIME_CYCLES |-> diff_tx_data == $past(fiber_rx, `RFD_PATH_LAT))
    else $error("fibre data not copied to bus"); // RL1

  drive_cycle_c: cover property (
    dir_state == DIR_LISTEN ##1 dir_state == DIR_DRIVE ##[1:1000] dir_state == DIR_HOLD);

  hold_restart_c: cover property (
    dir_state == DIR_HOLD ##1 dir_state == DIR_DRIVE);

  noecho_release_c: cover property (
    mode == MODE_NO_ECHO && $fell(diff_tx_en));

  fault_seen_c: cover property (
    mode_fault);

endmodule : rfd_direction_ctrl

// ---- rfd_bus_node.sv ----
/*
  Remote differential bus node beside the direction controller.
  Assumes the receive pair is shared with the device driver in the
  bus modes and separate in full duplex; termination fixes the rest level.
*/
`timescale 1ns/1ps

module rfd_bus_node (
  // Device driver side
  input  wire logic drv_data,
  input  wire logic drv_en,
  input  wire logic shared_pair,
  // Remote node
  input  wire logic node_en,
  input  wire logic node_data,
  // Receive pair
  output logic      line
);
  // A released pair settles at the rest level, not at the last bit
  always_comb begin
    if (shared_pair && drv_en) begin
      line = drv_data;
    end else if (node_en) begin
      line = node_data;
    end else begin
      line = 1'b1;
    end
  end
endmodule : rfd_bus_node

// ---- testbench.sv ----
/*
  Self-checking bench of the direction controller.
  Assumes rfd_pkg is compiled first and rfd_defines.svh is on the path.
*/
`timescale 1ns/1ps
`include "rfd_defines.svh"

module testbench;
  import rfd_pkg::*;
  logic           clk = 1'b0;
  logic           sys_rst = 1'b1;
  rfd_switch_type sw = 3'h1;
  logic           fib_rx = 1'b1;
  logic           node_en = 1'b0;
  logic           node_data = 1'b1;
  logic           shared = 1'b0;
  logic           fiber_tx, line, rx_en, tx_data, tx_en, fault;
  rfd_mode_type   mode;
  rfd_dir_type    dir;
  int             fail_count = 0;
  int             n_checks = 0;

  always #2.5 clk = ~clk;

  rfd_direction_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .mode_switch(sw), .fiber_rx(fib_rx),
    .fiber_tx(fiber_tx), .diff_rx(line), .diff_rx_en(rx_en), .diff_tx_data(tx_data),
    .diff_tx_en(tx_en), .mode(mode), .mode_fault(fault), .dir_state(dir));
  rfd_bus_node node (.drv_data(tx_data), .drv_en(tx_en), .shared_pair(shared),
    .node_en(node_en), .node_data(node_data), .line(line));

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_int(input string name, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_int

  task automatic chk_enum(input string name, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_enum

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // Counts cycles from the first idle bit until the driver lets go
  task automatic wait_off(output int n);
    n = 0;
    while (tx_en !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask : wait_off

  task automatic mode_table();
    rfd_mode_type em [8] = '{MODE_FULL_DUPLEX, MODE_FULL_DUPLEX, MODE_FULL_DUPLEX, MODE_ECHO,
                             MODE_FULL_DUPLEX, MODE_FULL_DUPLEX, MODE_FULL_DUPLEX, MODE_NO_ECHO};
    logic [7:0] ef = 8'h75;
    for (int i = 0; i < 8; i++) begin
      sw = 3'(i);
      cycles(3);
      chk_enum("mode", em[i], mode);
      chk_bit("mode_fault", ef[i], fault);
      chk_bit("diff_tx_en idle", em[i] == MODE_FULL_DUPLEX, tx_en);
      chk_bit("diff_rx_en idle", 1'b1, rx_en);
    end
  endtask : mode_table

  // Full duplex copy both ways, rep cycles per bit
  task automatic fd_stream(input logic [31:0] pat, input int rep);
    logic qf[$];
    logic qn[$];
    sw = 3'h1;
    shared = 1'b0;
    node_en = 1'b1;
    cycles(3);
    for (int i = 0; i < 32 * rep; i++) begin
      if (qf.size() >= `RFD_PATH_LAT) chk_bit("diff_tx_data", qf[qf.size() - `RFD_PATH_LAT], tx_data);
      if (qn.size() > 0) chk_bit("fiber_tx", qn[qn.size() - 1], fiber_tx);
      chk_bit("fd diff_tx_en", 1'b1, tx_en);
      chk_bit("fd diff_rx_en", 1'b1, rx_en);
      fib_rx = pat[i / rep];
      node_data = ~pat[i / rep];
      qf.push_back(fib_rx);
      qn.push_back(node_data);
      @(negedge clk);
    end
    fib_rx = 1'b1;
    node_en = 1'b0;
    cycles(10);
  endtask : fd_stream

  task automatic echo_case();
    int n;
    sw = 3'h3;
    shared = 1'b1;
    cycles(3);
    fib_rx = 1'b0;
    cycles(1);
    chk_bit("echo drive on", 1'b1, tx_en);
    cycles(9);
    chk_bit("echo diff_rx_en", 1'b1, rx_en);
    chk_bit("echo fiber_tx", 1'b0, fiber_tx);
    fib_rx = 1'b1;
    cycles(500);
    chk_bit("hold diff_tx_en", 1'b1, tx_en);
    fib_rx = 1'b0;
    cycles(1);
    fib_rx = 1'b1;
    wait_off(n);
    chk_int("restarted switchover", `RFD_HOLD_CYCLES, n);
    chk_enum("dir_state", DIR_LISTEN, dir);
  endtask : echo_case

  task automatic no_echo_case();
    int n;
    sw = 3'h7;
    shared = 1'b1;
    cycles(3);
    node_en = 1'b1;
    node_data = 1'b0;
    cycles(2);
    chk_bit("listen fiber_tx", 1'b0, fiber_tx);
    node_en = 1'b0;
    fib_rx = 1'b0;
    cycles(1);
    chk_bit("ne diff_tx_en", 1'b1, tx_en);
    chk_bit("ne diff_rx_en", 1'b0, rx_en);
    cycles(9);
    chk_bit("muted fiber_tx", 1'b1, fiber_tx);
    fib_rx = 1'b1;
    wait_off(n);
    chk_int("switchover", `RFD_HOLD_CYCLES, n);
    chk_bit("ne rx back", 1'b1, rx_en);
  endtask : no_echo_case

  // Switching to full duplex mid-transmission drops the automatic state
  task automatic abort_case();
    sw = 3'h3;
    cycles(3);
    fib_rx = 1'b0;
    cycles(3);
    sw = 3'h1;
    fib_rx = 1'b1;
    cycles(3);
    chk_enum("abort dir_state", DIR_LISTEN, dir);
    chk_bit("abort diff_tx_en", 1'b1, tx_en);
  endtask : abort_case

  initial begin
    cycles(20);
    chk_bit("reset diff_tx_en", 1'b0, tx_en);
    chk_bit("reset fiber_tx", 1'b1, fiber_tx);
    sys_rst = 1'b0;
    cycles(10);
    mode_table();
    fd_stream(32'hF0C3_A56E, 1);
    fd_stream(32'h00FF_0F35, 3);
    echo_case();
    no_echo_case();
    abort_case();
    tally_and_finish();
  end
endmodule : testbench
